/* logic/t4p_timer4.sv */
// Purpose: timer 4 register set, 8-bit timer/capture and six-output 10-bit PWM
// Assumes: single clock; capture_pin is asynchronous; byte register port
// Notes: period/duty writes take effect at once; read data follow a read by one cycle
// What this block does
// RL1: hold 10-bit PWM period, high bits 1:0 plus low byte, reset 0x0FF.
// RL2: hold 10-bit channel A duty across high and low registers, reset 0x07F.
// RL3: hold 10-bit channel B duty across high and low registers, reset 0x07F.
// RL4: hold 10-bit channel C duty across high and low registers, reset 0x07F.
// RL5: each of six outputs has a 4-bit rising-edge delay, reset zero.
// RL6: readable writable 8-bit compare register for timer and capture, reset 0xFF.
// RL7: read-only capture register holds captured count, reset zero.
// RL8: read-only counter register shows the current count, reset zero.
// RL9: control bit 7 joins timers 3 and 4 into one 16-bit timer.
// RL10: mode bit: clear toggles output on match, set captures with match event.
// RL11: continue bit clear pauses counting and keeps the count.
// RL12: start/stop bit written zero stops the counter.
// RL13: start/stop bit written one clears the counter and starts counting.
// RL14: clock select divides system clock; code 1111 is timer 3 clock, cascade only.
// RL15: unused high bits of period and duty registers read zero, ignore writes.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module t4p_timer4
    import t4p_pkg::*;
#(
    parameter int DIV_BITS = 14,
    parameter int DLY_BITS = 4
) (
    input wire logic clk, // system clock, 25 MHz
    input wire logic rst, // synchronous reset, high
    input wire logic ce, // clock enable, freezes all state when low
    input wire t4p_bus_req_t bus, // register request
    output logic [7:0] rdata, // read data, cycle after the read
    input wire logic t3_tick, // timer 3 clock enable
    input wire logic capture_pin, // asynchronous capture input
    output logic match_toggle_output, // toggles at compare match
    output logic pwm_out_a_first, // PWM channel A first output
    output logic pwm_out_a_second, // PWM channel A second output
    output logic pwm_out_b_first, // PWM channel B first output
    output logic pwm_out_b_second, // PWM channel B second output
    output logic pwm_out_c_first, // PWM channel C first output
    output logic pwm_out_c_second, // PWM channel C second output
    output logic irq // level interrupt
);
    t4p_ctrl_t ctrl;
    logic pwm_mode;
    logic [9:0] period;
    logic [9:0] duty [3];
    logic [7:0] dly [3];
    logic [7:0] compare;
    logic [7:0] captured;
    logic [7:0] count;
    logic [9:0] pwm_cnt;
    logic [T4P_EV_NUM-1:0] status;
    logic [T4P_EV_NUM-1:0] mask;
    logic [T4P_EV_NUM-1:0] events;
    logic [5:0] pwm_q;
    logic [5:0] target;
    logic [DLY_BITS-1:0] wait_cnt [6];
    logic cap_s1, cap_s2, cap_s3, cap_lvl;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        return a == ofs;
    endfunction

    // write decode
    wire wr_ctrl = bus.wr && hit(bus.addr, T4P_OFS_CTRL);
    wire wr_per_lo = bus.wr && hit(bus.addr, T4P_OFS_PER_LO);
    wire wr_per_hi = bus.wr && hit(bus.addr, T4P_OFS_PER_HI);
    wire wr_cmp = bus.wr && hit(bus.addr, T4P_OFS_CMP);
    wire wr_stat = bus.wr && hit(bus.addr, T4P_OFS_STAT);
    wire wr_mask = bus.wr && hit(bus.addr, T4P_OFS_MASK);
    wire wr_mode = bus.wr && hit(bus.addr, T4P_OFS_PWM_MODE);
    wire start_wr1 = wr_ctrl && bus.wdata[T4P_START_BIT];
    wire [15:0] duty_lo_ofs [3] = '{T4P_OFS_DA_LO, T4P_OFS_DB_LO, T4P_OFS_DC_LO};
    wire [15:0] duty_hi_ofs [3] = '{T4P_OFS_DA_HI, T4P_OFS_DB_HI, T4P_OFS_DC_HI};
    wire [15:0] dly_ofs [3] = '{T4P_OFS_DLY_A, T4P_OFS_DLY_B, T4P_OFS_DLY_C};

    // timer clock
    logic tick;
    t4p_prescaler #(
        .DIV_BITS(DIV_BITS)
    ) u_presc (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .sel(ctrl.clock_source_select),
        .cascade(ctrl.cascade_width_select),
        .t3_tick(t3_tick),
        .tick(tick)
    );

    // counting runs only with start set and continue set
    wire running = ctrl.count_start_stop && ctrl.count_continue; // see RL11
    wire step = running && tick && !start_wr1;
    wire match = step && !pwm_mode && (count == compare);
    wire per_end = step && pwm_mode && (pwm_cnt == period);
    wire cap_edge = cap_s2 && cap_s3 && !cap_lvl;
    wire cap_take = cap_edge && ctrl.capture_mode_select && !pwm_mode; // see RL10

    assign events[T4P_EV_MATCH] = match;
    assign events[T4P_EV_CAPTURE] = cap_take;
    assign events[T4P_EV_PERIOD] = per_end;

    // control and configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= T4P_CTRL_RST;
            pwm_mode <= 1'b0;
            period <= T4P_PERIOD_RST;
            compare <= T4P_CMP_RST;
            mask <= '0;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl <= bus.wdata; // see RL9
            end
            if (wr_mode) begin
                pwm_mode <= bus.wdata[0];
            end
            if (wr_per_lo) begin
                period[7:0] <= bus.wdata; // see RL1
            end
            if (wr_per_hi) begin
                period[9:8] <= bus.wdata[T4P_HI_BITS-1:0]; // see RL15
            end
            if (wr_cmp) begin
                compare <= bus.wdata; // see RL6
            end
            if (wr_mask) begin
                mask <= bus.wdata[T4P_EV_NUM-1:0];
            end
        end
    end

    // duty and delay registers, one per channel
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                duty[i] <= T4P_DUTY_RST; // see RL2 see RL3 see RL4
                dly[i] <= T4P_DLY_RST; // see RL5
            end
        end else if (ce) begin
            for (int i = 0; i < 3; i++) begin
                if (bus.wr && hit(bus.addr, duty_lo_ofs[i])) begin
                    duty[i][7:0] <= bus.wdata;
                end
                if (bus.wr && hit(bus.addr, duty_hi_ofs[i])) begin
                    duty[i][9:8] <= bus.wdata[T4P_HI_BITS-1:0]; // see RL15
                end
                if (bus.wr && hit(bus.addr, dly_ofs[i])) begin
                    dly[i] <= bus.wdata;
                end
            end
        end
    end

    // 8-bit timer, clears at compare match
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= T4P_CNT_RST;
            match_toggle_output <= 1'b0;
        end else if (ce) begin
            if (start_wr1) begin
                count <= '0; // see RL13
            end else if (match) begin
                count <= '0;
            end else if (step && !pwm_mode) begin
                count <= count + 1'b1; // see RL12
            end
            if (match && !ctrl.capture_mode_select) begin
                match_toggle_output <= !match_toggle_output; // see RL10
            end
        end
    end

    // 10-bit PWM counter, wraps after reaching the period
    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_cnt <= '0;
        end else if (ce) begin
            if (start_wr1 || per_end) begin
                pwm_cnt <= '0;
            end else if (step && pwm_mode) begin
                pwm_cnt <= pwm_cnt + 1'b1; // see RL1
            end
        end
    end

    // capture input: three flops, a rise counts once the last two agree
    always_ff @(posedge clk) begin
        if (rst) begin
            cap_s1 <= 1'b0;
            cap_s2 <= 1'b0;
            cap_s3 <= 1'b0;
            cap_lvl <= 1'b0;
            captured <= T4P_CAP_RST;
        end else if (ce) begin
            cap_s1 <= capture_pin;
            cap_s2 <= cap_s1;
            cap_s3 <= cap_s2;
            if (cap_s2 == cap_s3) begin
                cap_lvl <= cap_s3;
            end
            if (cap_take) begin
                captured <= count; // see RL7
            end
        end
    end

    // sticky status: a new event wins over a write-one clear
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= T4P_STAT_RST;
        end else if (ce) begin
            status <= (status & ~(wr_stat ? bus.wdata[T4P_EV_NUM-1:0] : '0)) | events;
        end
    end

    assign irq = |(status & mask);

    // first output follows duty, second its complement; delays hold back only rises
    generate
        for (genvar c = 0; c < 3; c++) begin : g_raw
            assign target[2*c] = pwm_mode && ctrl.count_start_stop && (pwm_cnt < duty[c]);
            assign target[2*c+1] = pwm_mode && ctrl.count_start_stop && !(pwm_cnt < duty[c]);
        end
    endgenerate

    function automatic logic [DLY_BITS-1:0] dly_of(input int i, input logic [7:0] r);
        return (i % 2 == 0) ? r[7:4] : r[3:0];
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_q <= '0;
            for (int i = 0; i < 6; i++) begin
                wait_cnt[i] <= '0;
            end
        end else if (ce) begin
            for (int i = 0; i < 6; i++) begin
                if (!target[i]) begin
                    pwm_q[i] <= 1'b0; // see RL5
                    wait_cnt[i] <= '0;
                end else if (!pwm_q[i]) begin
                    if (wait_cnt[i] >= dly_of(i, dly[i/2])) begin
                        pwm_q[i] <= 1'b1; // see RL5
                    end else if (tick) begin
                        wait_cnt[i] <= wait_cnt[i] + 1'b1;
                    end
                end
            end
        end
    end

    assign pwm_out_a_first = pwm_q[0];
    assign pwm_out_a_second = pwm_q[1];
    assign pwm_out_b_first = pwm_q[2];
    assign pwm_out_b_second = pwm_q[3];
    assign pwm_out_c_first = pwm_q[4];
    assign pwm_out_c_second = pwm_q[5];

    // read selection; unmapped addresses read zero
    wire [7:0] rd_sel =
        hit(bus.addr, T4P_OFS_CTRL) ? ctrl :
        hit(bus.addr, T4P_OFS_PER_LO) ? period[7:0] :
        hit(bus.addr, T4P_OFS_PER_HI) ? {6'h00, period[9:8]} : // see RL15
        hit(bus.addr, T4P_OFS_DA_LO) ? duty[0][7:0] :
        hit(bus.addr, T4P_OFS_DA_HI) ? {6'h00, duty[0][9:8]} :
        hit(bus.addr, T4P_OFS_DB_LO) ? duty[1][7:0] :
        hit(bus.addr, T4P_OFS_DB_HI) ? {6'h00, duty[1][9:8]} :
        hit(bus.addr, T4P_OFS_DC_LO) ? duty[2][7:0] :
        hit(bus.addr, T4P_OFS_DC_HI) ? {6'h00, duty[2][9:8]} :
        hit(bus.addr, T4P_OFS_DLY_A) ? dly[0] :
        hit(bus.addr, T4P_OFS_DLY_B) ? dly[1] :
        hit(bus.addr, T4P_OFS_DLY_C) ? dly[2] :
        hit(bus.addr, T4P_OFS_CMP) ? compare :
        hit(bus.addr, T4P_OFS_CAP) ? captured :
        hit(bus.addr, T4P_OFS_CNT) ? count : // see RL8
        hit(bus.addr, T4P_OFS_STAT) ? {5'h00, status} :
        hit(bus.addr, T4P_OFS_MASK) ? {5'h00, mask} :
        hit(bus.addr, T4P_OFS_PWM_MODE) ? {7'h00, pwm_mode} : 8'h00;

    // data only valid in the cycle after the read
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= bus.rd ? rd_sel : 8'h00;
        end
    end

    // checks
    period_reset_a: assert property (@(posedge clk) // see RL1
        rst |=> (period == T4P_PERIOD_RST))
        else $error("period not 0x0FF after reset");
    duty_reset_a: assert property (@(posedge clk) // see RL2
        rst |=> (duty[0] == T4P_DUTY_RST && duty[1] == T4P_DUTY_RST
            && duty[2] == T4P_DUTY_RST && compare == T4P_CMP_RST))
        else $error("duty or compare reset value wrong");
    duty_b_write_a: assert property (@(posedge clk) disable iff (rst) // see RL3
        (ce && bus.wr && hit(bus.addr, T4P_OFS_DB_HI))
            |=> (duty[1][9:8] == $past(bus.wdata[1:0])))
        else $error("duty B high bits not stored");
    duty_c_read_a: assert property (@(posedge clk) disable iff (rst) // see RL4
        (ce && bus.rd && hit(bus.addr, T4P_OFS_DC_LO)) |=> (rdata == $past(duty[2][7:0])))
        else $error("duty C low readback wrong");
    fall_immediate_a: assert property (@(posedge clk) disable iff (rst) // see RL5
        (ce && !target[0]) |=> !pwm_out_a_first)
        else $error("first output fall was delayed");
    rise_delay_a: assert property (@(posedge clk) disable iff (rst) // see RL5
        (ce && $rose(target[1]) && dly[0][3:0] != 4'h0) |=> !pwm_out_a_second)
        else $error("second output rose without its delay");
    capture_ro_a: assert property (@(posedge clk) disable iff (rst) // see RL7
        (ce && bus.wr && hit(bus.addr, T4P_OFS_CAP) && !cap_take) |=> $stable(captured))
        else $error("capture register was written");
    count_read_a: assert property (@(posedge clk) disable iff (rst) // see RL8
        (ce && bus.rd && hit(bus.addr, T4P_OFS_CNT)) |=> (rdata == $past(count)))
        else $error("counter readback wrong");
    toggle_match_a: assert property (@(posedge clk) disable iff (rst) // see RL10
        (match && !ctrl.capture_mode_select) |=> (match_toggle_output != $past(match_toggle_output)))
        else $error("no toggle at compare match");
    pause_hold_a: assert property (@(posedge clk) disable iff (rst) // see RL11
        (!ctrl.count_continue && !wr_ctrl) |=> $stable(count))
        else $error("count moved while paused");
    stop_hold_a: assert property (@(posedge clk) disable iff (rst) // see RL12
        (ce && wr_ctrl && !bus.wdata[T4P_START_BIT]) ##1 (!wr_ctrl)[*2] |-> $stable(count))
        else $error("count moved after stop");
    start_clear_a: assert property (@(posedge clk) disable iff (rst) // see RL13
        (ce && start_wr1) |=> (count == 8'h00 && pwm_cnt == 10'h000))
        else $error("start did not clear the counter");
    cascade_sel_a: assert property (@(posedge clk) disable iff (rst) // see RL9
        (ce && wr_ctrl) |=> (ctrl.cascade_width_select == $past(bus.wdata[T4P_CASCADE_BIT])))
        else $error("cascade select not stored");
    high_zero_a: assert property (@(posedge clk) disable iff (rst) // see RL15
        (ce && bus.rd && hit(bus.addr, T4P_OFS_PER_HI)) |=> (rdata[7:2] == 6'h00))
        else $error("unused period bits read nonzero");
    compare_write_a: assert property (@(posedge clk) disable iff (rst) // see RL6
        (ce && wr_cmp) |=> (compare == $past(bus.wdata)))
        else $error("compare write not stored");
    period_low_a: assert property (@(posedge clk) disable iff (rst) // see RL1
        (ce && wr_per_lo) |=> (period[7:0] == $past(bus.wdata)))
        else $error("period low byte not stored");
    mode_sel_a: assert property (@(posedge clk) disable iff (rst) // see RL10
        (ce && wr_ctrl) |=> (ctrl.capture_mode_select == $past(bus.wdata[T4P_MODE_BIT])))
        else $error("mode select not stored");
endmodule

/* logic/t4p_pkg.sv */
// Purpose: shared constants and types of the timer 4 / 10-bit PWM register set
// Assumes: byte-wide registers in the extended special register space
// Notes: status, mask and PWM mode registers sit after the documented block
package t4p_pkg;
    // register offsets
    localparam logic [15:0] T4P_OFS_CTRL = 16'h1002;
    localparam logic [15:0] T4P_OFS_PER_LO = 16'h1008;
    localparam logic [15:0] T4P_OFS_PER_HI = 16'h1009;
    localparam logic [15:0] T4P_OFS_DA_LO = 16'h100A;
    localparam logic [15:0] T4P_OFS_DA_HI = 16'h100B;
    localparam logic [15:0] T4P_OFS_DB_LO = 16'h100C;
    localparam logic [15:0] T4P_OFS_DB_HI = 16'h100D;
    localparam logic [15:0] T4P_OFS_DC_LO = 16'h100E;
    localparam logic [15:0] T4P_OFS_DC_HI = 16'h100F;
    localparam logic [15:0] T4P_OFS_DLY_A = 16'h1010;
    localparam logic [15:0] T4P_OFS_DLY_B = 16'h1011;
    localparam logic [15:0] T4P_OFS_DLY_C = 16'h1012;
    localparam logic [15:0] T4P_OFS_CMP = 16'h1013;
    localparam logic [15:0] T4P_OFS_CAP = 16'h1014;
    localparam logic [15:0] T4P_OFS_CNT = 16'h1015;
    localparam logic [15:0] T4P_OFS_STAT = 16'h1016;
    localparam logic [15:0] T4P_OFS_MASK = 16'h1017;
    localparam logic [15:0] T4P_OFS_PWM_MODE = 16'h1018;

    // reset values
    localparam logic [7:0] T4P_CTRL_RST = 8'h00;
    localparam logic [9:0] T4P_PERIOD_RST = 10'h0FF;
    localparam logic [9:0] T4P_DUTY_RST = 10'h07F;
    localparam logic [7:0] T4P_DLY_RST = 8'h00;
    localparam logic [7:0] T4P_CMP_RST = 8'hFF;
    localparam logic [7:0] T4P_CAP_RST = 8'h00;
    localparam logic [7:0] T4P_CNT_RST = 8'h00;
    localparam logic [2:0] T4P_STAT_RST = 3'h0;

    // control field positions
    localparam int T4P_CASCADE_BIT = 7;
    localparam int T4P_MODE_BIT = 6;
    localparam int T4P_CONT_BIT = 5;
    localparam int T4P_START_BIT = 4;
    localparam int T4P_CKSEL_LSB = 0;
    localparam logic [3:0] T4P_CKSEL_T3 = 4'hF;

    // status / mask bit positions
    localparam int T4P_EV_MATCH = 0;
    localparam int T4P_EV_CAPTURE = 1;
    localparam int T4P_EV_PERIOD = 2;
    localparam int T4P_EV_NUM = 3;

    // width of the high period/duty field
    localparam int T4P_HI_BITS = 2;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } t4p_bus_req_t;

    typedef struct packed {
        logic cascade_width_select;
        logic capture_mode_select;
        logic count_continue;
        logic count_start_stop;
        logic [3:0] clock_source_select;
    } t4p_ctrl_t;
endpackage

/* logic/t4p_prescaler.sv */
// Purpose: timer clock-select tick generator from the system clock
// Assumes: the timer 3 clock arrives as a one-cycle enable on clk
// Notes: code n gives one tick every 2**n cycles, code 15 the timer 3 tick
`timescale 1ns/1ps
module t4p_prescaler
    import t4p_pkg::*;
#(
    parameter int DIV_BITS = 14
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, high
    input wire logic ce, // clock enable
    input wire logic [3:0] sel, // clock source code
    input wire logic cascade, // 16-bit cascade active
    input wire logic t3_tick, // timer 3 clock enable
    output logic tick // selected timer clock enable
);
    logic [DIV_BITS-1:0] div_cnt;
    logic [DIV_BITS-1:0] div_mask;
    logic div_hit;

    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt <= '0;
        end else if (ce) begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    assign div_mask = DIV_BITS'((1 << sel) - 1);
    assign div_hit = ((div_cnt & div_mask) == '0);
    // timer 3 clock is unusable while the timers run as two 8-bit halves
    assign tick = ce && ((sel == T4P_CKSEL_T3) ? (cascade && t3_tick) : div_hit); // see RL14

    t3_gated_a: assert property (@(posedge clk) disable iff (rst) // see RL14
        (sel == T4P_CKSEL_T3 && !cascade) |-> !tick)
        else $error("timer 3 clock used without cascade");
    div_rate_a: assert property (@(posedge clk) disable iff (rst) // see RL14
        (ce && sel == 4'h1 && tick) |=> (ce && $stable(sel)) |-> !tick)
        else $error("divide by two ticked twice in a row");
endmodule

/* dv/timer4_pwm_register_set_tb.sv */
// Purpose: self-checking bench for the timer 4 / 10-bit PWM register set
// Assumes: byte register port, read data one cycle after the read strobe
// Notes: prescaler shortened to 4 divider bits to keep runs short
`timescale 1ns/1ps
module timer4_pwm_register_set_tb;
    import t4p_pkg::*;
    logic clk;
    logic rst;
    logic ce;
    t4p_bus_req_t bus;
    logic [7:0] rdata;
    logic t3_tick;
    logic capture_pin;
    logic mto;
    logic [5:0] pwm;
    logic irq;
    int err_count;
    int checked;
    logic [15:0] ra [17] = '{T4P_OFS_CTRL, T4P_OFS_PER_LO, T4P_OFS_PER_HI, T4P_OFS_DA_LO,
        T4P_OFS_DA_HI, T4P_OFS_DB_LO, T4P_OFS_DB_HI, T4P_OFS_DC_LO, T4P_OFS_DC_HI,
        T4P_OFS_DLY_A, T4P_OFS_DLY_B, T4P_OFS_DLY_C, T4P_OFS_CMP, T4P_OFS_CAP,
        T4P_OFS_CNT, T4P_OFS_STAT, T4P_OFS_MASK};
    logic [7:0] rv [17] = '{8'h00, 8'hFF, 8'h00, 8'h7F, 8'h00, 8'h7F, 8'h00, 8'h7F,
        8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] wv [15] = '{8'hA6, 8'hA6, 8'h02, 8'hA6, 8'h02, 8'hA6, 8'h02, 8'hA6,
        8'h02, 8'hA6, 8'hA6, 8'hA6, 8'hA6, 8'h00, 8'h00};
    // high-cycle counts over one 10-cycle PWM period, three setups
    int pexp [3][6] = '{'{3, 7, 5, 5, 8, 2}, '{1, 6, 3, 4, 6, 1}, '{10, 0, 3, 4, 6, 1}};
    int hc [6];
    int n;
    int i;
    int j;
    logic [7:0] v;

    t4p_timer4 #(.DIV_BITS(4), .DLY_BITS(4)) t4p_timer4_i (
        .clk(clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata), .t3_tick(t3_tick),
        .capture_pin(capture_pin), .match_toggle_output(mto),
        .pwm_out_a_first(pwm[5]), .pwm_out_a_second(pwm[4]), .pwm_out_b_first(pwm[3]),
        .pwm_out_b_second(pwm[2]), .pwm_out_c_first(pwm[1]), .pwm_out_c_second(pwm[0]),
        .irq(irq));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // timer 3 clock enable every second cycle
    always @(posedge clk) t3_tick <= rst ? 1'b0 : ~t3_tick;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        // let the write settle before anything looks at combinational outputs
        @(negedge clk);
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask

    task automatic idle(input int c);
        repeat (c) @(negedge clk);
    endtask

    // cycles between two successive changes of the match output
    task automatic tog_period(output int p);
        logic t;
        int k;
        t = mto;
        for (k = 0; k < 600 && mto === t; k++) @(negedge clk);
        t = mto;
        p = 0;
        while (p < 600 && mto === t) begin
            @(negedge clk);
            p++;
        end
    endtask

    task automatic hi_count(input int c);
        int k;
        hc = '{0, 0, 0, 0, 0, 0};
        repeat (c) begin
            @(negedge clk);
            for (k = 0; k < 6; k++) hc[k] += (pwm[5-k] === 1'b1);
        end
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        err_count++;
        close_out();
    end

    initial begin
        err_count = 0;
        checked = 0;
        rst = 1'b1;
        ce = 1'b1;
        bus = '0;
        capture_pin = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 17; i++) rchk(ra[i], rv[i]);
        for (i = 0; i < 15; i++) wr(ra[i], 8'hA6);
        for (i = 0; i < 15; i++) rchk(ra[i], wv[i]);
        rchk(16'h1030, 8'h00);
        wr(T4P_OFS_CTRL, 8'h00);
        wr(T4P_OFS_CMP, 8'h03);
        // clock codes 0..3: toggle every (compare+1) * 2**code cycles
        for (i = 0; i < 4; i++) begin
            wr(T4P_OFS_CTRL, 8'h30 | i[7:0]);
            tog_period(n);
            chk(n[15:0], 16'd4 << i);
        end
        wr(T4P_OFS_CMP, 8'hFF);
        wr(T4P_OFS_CTRL, 8'h30);
        idle(20);
        wr(T4P_OFS_CTRL, 8'h20);
        rd(T4P_OFS_CNT, v);
        chk(v > 8'd10 && v < 8'd30, 16'd1);
        idle(10);
        rchk(T4P_OFS_CNT, v);
        wr(T4P_OFS_CTRL, 8'h30);
        rd(T4P_OFS_CNT, v);
        chk(v < 8'd4, 16'd1);
        wr(T4P_OFS_CTRL, 8'h10);
        idle(12);
        rchk(T4P_OFS_CNT, 8'h00);
        wr(T4P_OFS_CTRL, 8'h3F);
        idle(12);
        rchk(T4P_OFS_CNT, 8'h00);
        wr(T4P_OFS_CTRL, 8'hBF);
        idle(20);
        wr(T4P_OFS_CTRL, 8'hAF);
        rd(T4P_OFS_CNT, v);
        chk(v > 8'd5 && v < 8'd16, 16'd1);
        // capture mode: no toggling, match and capture events, interrupt
        wr(T4P_OFS_CTRL, 8'h00);
        wr(T4P_OFS_CMP, 8'h03);
        wr(T4P_OFS_STAT, 8'h07);
        rchk(T4P_OFS_STAT, 8'h00);
        chk(irq, 1'b0);
        wr(T4P_OFS_CTRL, 8'h70);
        v = {7'h00, mto};
        idle(10);
        @(posedge clk) capture_pin <= 1'b1;
        idle(20);
        chk(mto, v[0]);
        wr(T4P_OFS_CTRL, 8'h60);
        rchk(T4P_OFS_STAT, 8'h03);
        rd(T4P_OFS_CAP, v);
        chk(v < 8'd4, 16'd1);
        chk(irq, 1'b0);
        wr(T4P_OFS_MASK, 8'h02);
        chk(irq, 1'b1);
        wr(T4P_OFS_STAT, 8'h03);
        chk(irq, 1'b0);
        rchk(T4P_OFS_STAT, 8'h00);
        // six-output PWM, period 9, duties 3/5/8, then delays, then 10-bit duty
        wr(T4P_OFS_CTRL, 8'h00);
        wr(T4P_OFS_PWM_MODE, 8'h01);
        wr(T4P_OFS_PER_LO, 8'h09);
        wr(T4P_OFS_PER_HI, 8'h00);
        // clear the high duty bits and delays left over from the pattern written earlier
        for (i = 4; i < 9; i += 2) wr(ra[i], 8'h00);
        for (i = 9; i < 12; i++) wr(ra[i], 8'h00);
        wr(T4P_OFS_DA_LO, 8'h03);
        wr(T4P_OFS_DB_LO, 8'h05);
        wr(T4P_OFS_DC_LO, 8'h08);
        wr(T4P_OFS_CTRL, 8'h30);
        for (j = 0; j < 3; j++) begin
            if (j == 1) begin
                wr(T4P_OFS_DLY_A, 8'h21);
                wr(T4P_OFS_DLY_B, 8'h21);
                wr(T4P_OFS_DLY_C, 8'h21);
            end
            if (j == 2) wr(T4P_OFS_DA_HI, 8'h01);
            idle(25);
            hi_count(10);
            for (i = 0; i < 6; i++) chk(hc[i][15:0], pexp[j][i][15:0]);
        end
        rd(T4P_OFS_STAT, v);
        chk(v & 8'h04, 8'h04);
        wr(T4P_OFS_CTRL, 8'h00);
        idle(3);
        hi_count(10);
        for (i = 0; i < 6; i++) chk(hc[i][15:0], 16'd0);
        close_out();
    end
endmodule
